/* hw/ac_pkg.sv */
// constants, field positions and helpers shared by the serial channel files
package ac_pkg;
	// register offsets on the 3-bit host address
	localparam logic [2:0] AC_A_DATA = 3'h0; // receive_buffer / transmit_holding / divisor low
	localparam logic [2:0] AC_A_IER = 3'h1; // interrupt enable / divisor high
	localparam logic [2:0] AC_A_IIR = 3'h2; // interrupt_ident_reg (write: pending clear)
	localparam logic [2:0] AC_A_LCR = 3'h3;
	localparam logic [2:0] AC_A_MCR = 3'h4;
	localparam logic [2:0] AC_A_LSR = 3'h5;
	localparam logic [2:0] AC_A_MSR = 3'h6;
	localparam logic [2:0] AC_A_SCR = 3'h7;
	// interrupt source bits, same layout for pending and enable
	localparam int AC_SRC_RDA = 0;
	localparam int AC_SRC_TX_HOLDING_EMPTY = 1;
	localparam int AC_SRC_RLS = 2;
	localparam int AC_SRC_MS = 3;
	// line control fields
	localparam int AC_LCR_WLS = 0;
	localparam int AC_LCR_STB = 2;
	localparam int AC_LCR_PEN = 3;
	localparam int AC_LCR_EPS = 4;
	localparam int AC_LCR_DIVISOR_ACCESS_BIT = 7;
	// modem control fields
	localparam int AC_MCR_DTR = 0;
	localparam int AC_MCR_RTS = 1;
	// reset values
	localparam logic [7:0] AC_LCR_RST = 8'h00;
	localparam logic [3:0] AC_MCR_PINS_N_RST = 4'hf;
	localparam logic [3:0] AC_IER_RST = 4'h0;
	localparam logic [15:0] AC_DIV_RST = 16'h0001;
	// identification codes
	localparam logic [7:0] AC_IIR_NONE = 8'h01;
	localparam logic [7:0] AC_IIR_RLS = 8'h06;
	localparam logic [7:0] AC_IIR_RDA = 8'h04;
	localparam logic [7:0] AC_IIR_TX_HOLDING_EMPTY = 8'h02;
	localparam logic [7:0] AC_IIR_MS = 8'h00;
	// timing in baud ticks
	localparam logic [4:0] AC_TICKS_PER_BIT = 5'h10;
	localparam logic [4:0] AC_TX_START_TICKS = 5'h10;
	localparam logic [4:0] AC_EVT_TICKS = 5'h08;
	localparam logic [3:0] AC_MID_TICKS = 4'h8;

	// data bits per character from the word length field
	function automatic logic [3:0] ac_word_bits(input logic [1:0] wls);
		return 4'h5 + {2'h0, wls};
	endfunction
endpackage

/* hw/ac_tx_if.sv */
// link between the channel core and its transmitter
`timescale 1ns/10ps
`default_nettype none
interface ac_tx_if;
	logic tick;
	logic wr;
	logic [7:0] wr_data;
	logic [7:0] lcr;
	logic serial_out;
	logic hold_empty;
	logic shift_empty;
	logic tx_holding_empty_evt;
	modport ctl (output tick, wr, wr_data, lcr, input serial_out, hold_empty, shift_empty, tx_holding_empty_evt);
	modport tx (input tick, wr, wr_data, lcr, output serial_out, hold_empty, shift_empty, tx_holding_empty_evt);
endinterface
`default_nettype wire

/* hw/ac_tx.sv */
// transmitter: holding register, shifter and holding-empty event
`timescale 1ns/10ps
`default_nettype none
module ac_tx (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// core side
	ac_tx_if.tx bus
);
	import ac_pkg::*;
	typedef enum logic [5:0] {
		TX_IDLE = 6'b000001, TX_WAIT = 6'b000010, TX_START = 6'b000100,
		TX_DATA = 6'b001000, TX_PAR = 6'b010000, TX_STOP = 6'b100000
	} ac_tx_e;
	ac_tx_e st_q;
	logic [4:0] cnt_q;
	logic [2:0] bit_q;
	logic [7:0] hold_q, sh_q;
	logic hold_full_q, par_q, out_q, evt_q;
	logic [3:0] wb;
	logic [4:0] stop_last;
	logic xfer;

	assign wb = ac_word_bits(bus.lcr[AC_LCR_WLS +: 2]);
	assign stop_last = bus.lcr[AC_LCR_STB] ? 5'h1f : 5'h0f;
	// holding moves into the shifter on these ticks
	assign xfer = bus.tick && ((st_q == TX_WAIT && cnt_q == AC_TX_START_TICKS - 5'h01) ||
		(st_q == TX_STOP && cnt_q == stop_last && hold_full_q));

	// holding register; a write in the transfer cycle keeps the new byte pending
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hold_q <= 8'h00;
			hold_full_q <= 1'b0;
		end else if (bus.wr) begin
			hold_q <= bus.wr_data;
			hold_full_q <= 1'b1;
		end else if (xfer) begin
			hold_full_q <= 1'b0;
		end
	end

	// character sequencer, one bit per sixteen ticks
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_q <= TX_IDLE;
			cnt_q <= 5'h00;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			par_q <= 1'b0;
		end else if (st_q == TX_IDLE) begin
			if (hold_full_q) begin
				st_q <= TX_WAIT;
				cnt_q <= 5'h00;
			end
		end else if (bus.tick) begin
			cnt_q <= cnt_q + 5'h01;
			if (xfer) begin
				st_q <= TX_START;
				cnt_q <= 5'h00;
				sh_q <= hold_q & (8'hff >> (4'h8 - wb));
				par_q <= ^(hold_q & (8'hff >> (4'h8 - wb))) ^ ~bus.lcr[AC_LCR_EPS];
			end else begin
				unique case (st_q)
					TX_START: if (cnt_q == AC_TICKS_PER_BIT - 5'h01) begin
						st_q <= TX_DATA;
						cnt_q <= 5'h00;
						bit_q <= 3'h0;
					end
					TX_DATA: if (cnt_q == AC_TICKS_PER_BIT - 5'h01) begin
						cnt_q <= 5'h00;
						sh_q <= sh_q >> 1;
						bit_q <= bit_q + 3'h1;
						if ({1'b0, bit_q} == wb - 4'h1) begin
							st_q <= bus.lcr[AC_LCR_PEN] ? TX_PAR : TX_STOP;
						end
					end
					TX_PAR: if (cnt_q == AC_TICKS_PER_BIT - 5'h01) begin
						st_q <= TX_STOP;
						cnt_q <= 5'h00;
					end
					TX_STOP: if (cnt_q == stop_last) begin
						st_q <= TX_IDLE;
					end
					default: st_q <= st_q; // wait counts until the transfer tick
				endcase
			end
		end
	end

	// line driver, high whenever no character is on the wire
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			out_q <= 1'b1;
		end else begin
			out_q <= (st_q == TX_START) ? 1'b0 : (st_q == TX_DATA) ? sh_q[0] :
				(st_q == TX_PAR) ? par_q : 1'b1;
		end
	end

	// event eight ticks into the start bit, or into the stop bit if nothing waits
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			evt_q <= 1'b0;
		end else begin
			evt_q <= bus.tick && cnt_q == AC_EVT_TICKS - 5'h01 &&
				(st_q == TX_START || (st_q == TX_STOP && !hold_full_q));
		end
	end

	assign bus.serial_out = out_q;
	assign bus.hold_empty = !hold_full_q;
	assign bus.shift_empty = (st_q == TX_IDLE);
	assign bus.tx_holding_empty_evt = evt_q;

	// helper: ticks since the last holding write, and first-write marker
	logic [5:0] tk_q;
	logic init_q;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tk_q <= 6'h00;
			init_q <= 1'b0;
		end else begin
			tk_q <= bus.wr ? 6'h00 : (bus.tick && tk_q != 6'h3f) ? tk_q + 6'h01 : tk_q;
			init_q <= (bus.wr && st_q == TX_IDLE && !hold_full_q) ? 1'b1 : evt_q ? 1'b0 : init_q;
		end
	end

	default clocking dcb @(posedge clock); endclocking
	default disable iff (!nrst);
	a_start_delay: assert property (init_q && xfer && st_q == TX_WAIT |->
		tk_q >= 6'h07 && tk_q <= 6'h17 ##2 !out_q) // line driver lags the state by one edge
		else $error("start bit outside 8..24 ticks after write");
	a_stop_event: assert property (bus.tick && st_q == TX_STOP && cnt_q == 5'h07 &&
		!hold_full_q |=> evt_q ##1 !evt_q)
		else $error("stop event not 8 ticks into stop bit");
	a_tx_holding_empty_delay: assert property (evt_q && init_q |-> tk_q >= 6'h10 && tk_q <= 6'h20)
		else $error("holding-empty event outside 16..32 ticks");
	c_tx_char: cover property (st_q == TX_STOP ##1 st_q == TX_IDLE);
endmodule
`default_nettype wire

/* hw/ac_uart.sv */
// serial channel core: host registers, receiver, modem lines, interrupt
//
// What this block does
// - receive interrupt one tick after stop sample
// - reading receive buffer or line status clears
// - start bit 8 to 24 ticks after write
// - transmit interrupt 8 ticks after stop position
// - holding-empty interrupt 16 to 32 ticks after write
// - holding write clears holding-empty interrupt
// - identification read clears holding-empty interrupt
// - cts, dsr or carrier change, or ring going inactive, sets modem interrupt
// - modem status read clears modem interrupt
// - modem control write updates request and ready
// - reset sets empty flags, line idles high
// - divisor access bit maps offsets to divisor
`timescale 1ns/10ps
`default_nettype none
module ac_uart (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// host register port
	input wire logic [2:0] host_addr,
	input wire logic [7:0] host_wr_data,
	input wire logic host_write_strobe,
	input wire logic host_read_strobe,
	output logic [7:0] host_rd_data,
	// serial line
	input wire logic serial_in,
	output logic serial_out,
	// modem lines, active low
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic carrier_detect_in_n,
	output logic rts_n,
	output logic dtr_n,
	output logic out1_n,
	output logic out2_n,
	// interrupt
	output logic interrupt_out
);
	import ac_pkg::*;
	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
		RX_PAR = 5'b01000, RX_STOP = 5'b10000
	} ac_rx_e;

	ac_tx_if txb ();
	ac_tx u_tx (.clock(clock), .nrst(nrst), .bus(txb.tx));

	logic [7:0] lcr_q, scr_q, dll_q, dlm_q, rd_data_q, receive_buffer_q, rx_sh_q;
	logic [3:0] ier_q, pins_n_q, pend_q, delta_q, prev_q;
	logic [15:0] div_cnt_q;
	logic [4:0] sync1_q, sync2_q;
	logic tick_q, dr_q, oe_q, pe_q, fe_q, rx_stop_q, rx_par_q, ms_live_q;
	ac_rx_e rx_q;
	logic [3:0] rx_cnt_q;
	logic [2:0] rx_bit_q;

	// host access decode
	logic divisor_access_bit, wr_thr, rd_rbr, rd_lsr, rd_iir, rd_msr, wr_mcr, wr_iir;
	assign divisor_access_bit = lcr_q[AC_LCR_DIVISOR_ACCESS_BIT];
	assign wr_thr = host_write_strobe && host_addr == AC_A_DATA && !divisor_access_bit;
	assign rd_rbr = host_read_strobe && host_addr == AC_A_DATA && !divisor_access_bit;
	assign rd_lsr = host_read_strobe && host_addr == AC_A_LSR;
	assign rd_iir = host_read_strobe && host_addr == AC_A_IIR;
	assign rd_msr = host_read_strobe && host_addr == AC_A_MSR;
	assign wr_mcr = host_write_strobe && host_addr == AC_A_MCR;
	assign wr_iir = host_write_strobe && host_addr == AC_A_IIR;

	// two-flop synchronisers: serial_in, cts, dsr, ri, carrier
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= 5'h1f;
			sync2_q <= 5'h1f;
		end else begin
			sync1_q <= {carrier_detect_in_n, ri_n, dsr_n, cts_n, serial_in};
			sync2_q <= sync1_q;
		end
	end

	// baud tick divider; a zero divisor behaves as one
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			div_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_cnt_q + 16'h0001 >= {dlm_q, dll_q}) begin
			div_cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// configuration registers written by the host
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			lcr_q <= AC_LCR_RST;
			ier_q <= AC_IER_RST;
			scr_q <= 8'h00;
			{dlm_q, dll_q} <= AC_DIV_RST;
		end else if (host_write_strobe) begin
			unique case (host_addr)
				AC_A_DATA: if (divisor_access_bit) dll_q <= host_wr_data;
				AC_A_IER: if (divisor_access_bit) dlm_q <= host_wr_data; else ier_q <= host_wr_data[3:0];
				AC_A_LCR: lcr_q <= host_wr_data;
				AC_A_SCR: scr_q <= host_wr_data;
				default: ;
			endcase
		end
	end

	// modem control pins change on the write itself
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pins_n_q <= AC_MCR_PINS_N_RST;
		end else if (wr_mcr) begin
			pins_n_q <= ~host_wr_data[3:0];
		end
	end
	assign {out2_n, out1_n, rts_n, dtr_n} = pins_n_q;

	// receiver: mid-bit sampling at sixteen ticks per bit
	logic [3:0] wb;
	assign wb = ac_word_bits(lcr_q[AC_LCR_WLS +: 2]);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_q <= RX_IDLE;
			rx_cnt_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_par_q <= 1'b0;
			rx_stop_q <= 1'b0;
			fe_q <= 1'b0;
		end else if (tick_q) begin
			rx_cnt_q <= rx_cnt_q + 4'h1;
			rx_stop_q <= (rx_q == RX_STOP && rx_cnt_q == 4'hf);
			unique case (rx_q)
				RX_IDLE: if (!sync2_q[0]) begin
					rx_q <= RX_START;
					rx_cnt_q <= 4'h0;
				end
				RX_START: if (rx_cnt_q == AC_MID_TICKS - 4'h1) begin
					rx_q <= sync2_q[0] ? RX_IDLE : RX_DATA; // glitch is not a start
					rx_cnt_q <= 4'h0;
					rx_bit_q <= 3'h0;
				end
				RX_DATA: if (rx_cnt_q == 4'hf) begin
					rx_sh_q <= {sync2_q[0], rx_sh_q[7:1]};
					rx_bit_q <= rx_bit_q + 3'h1;
					if ({1'b0, rx_bit_q} == wb - 4'h1) begin
						rx_q <= lcr_q[AC_LCR_PEN] ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: if (rx_cnt_q == 4'hf) begin
					rx_par_q <= sync2_q[0];
					rx_q <= RX_STOP;
				end
				RX_STOP: if (rx_cnt_q == 4'hf) begin
					fe_q <= !sync2_q[0];
					rx_q <= RX_IDLE;
				end
				default: rx_q <= RX_IDLE;
			endcase
		end
	end

	// character completes one tick after the stop sample
	logic rx_done, rx_pe;
	logic [7:0] rx_word;
	assign rx_done = rx_stop_q && tick_q;
	assign rx_word = rx_sh_q >> (4'h8 - wb);
	assign rx_pe = lcr_q[AC_LCR_PEN] && (rx_par_q != ((^rx_word) ^ ~lcr_q[AC_LCR_EPS]));

	// line status flags; a new character wins over a clearing read
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dr_q <= 1'b0;
			oe_q <= 1'b0;
			pe_q <= 1'b0;
			receive_buffer_q <= 8'h00;
		end else if (rx_done) begin
			dr_q <= 1'b1;
			oe_q <= dr_q && !rd_rbr;
			pe_q <= rx_pe;
			receive_buffer_q <= rx_word;
		end else begin
			if (rd_rbr) dr_q <= 1'b0;
			if (rd_lsr) begin
				oe_q <= 1'b0;
				pe_q <= 1'b0;
			end
		end
	end

	// modem input deltas, armed one cycle after reset; a cts, dsr or carrier level active at start-up sets its delta
	logic [3:0] mod_now, mod_chg;
	assign mod_now = ~sync2_q[4:1];
	assign mod_chg = {mod_now[3] ^ prev_q[3], prev_q[2] & ~mod_now[2],
		mod_now[1] ^ prev_q[1], mod_now[0] ^ prev_q[0]} & {4{ms_live_q}};
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prev_q <= 4'h0;
			delta_q <= 4'h0;
			ms_live_q <= 1'b0;
		end else begin
			prev_q <= mod_now;
			ms_live_q <= 1'b1;
			delta_q <= (rd_msr ? 4'h0 : delta_q) | mod_chg;
		end
	end

	// pending interrupt sources; every set wins over a clear in the same cycle
	logic [3:0] pend_set, pend_clr;
	logic lsr_err;
	assign lsr_err = rx_done && (rx_pe || dr_q || !sync2_q[0]);
	assign pend_set = {|mod_chg, lsr_err, txb.tx_holding_empty_evt, rx_done};
	assign pend_clr = {rd_msr, rd_lsr, wr_thr || rd_iir, rd_rbr || rd_lsr} |
		(wr_iir ? host_wr_data[3:0] : 4'h0);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pend_q <= 4'h0;
		end else begin
			pend_q <= (pend_q & ~pend_clr) | pend_set;
		end
	end
	assign interrupt_out = |(pend_q & ier_q);

	// transmitter hookup
	assign txb.tick = tick_q;
	assign txb.wr = wr_thr;
	assign txb.wr_data = host_wr_data;
	assign txb.lcr = lcr_q;
	assign serial_out = txb.serial_out;

	// read mux, answer registered for the cycle after the strobe only
	logic [3:0] act;
	logic [7:0] iir_val, rd_mux;
	assign act = pend_q & ier_q;
	assign iir_val = act[AC_SRC_RLS] ? AC_IIR_RLS : act[AC_SRC_RDA] ? AC_IIR_RDA :
		act[AC_SRC_TX_HOLDING_EMPTY] ? AC_IIR_TX_HOLDING_EMPTY : act[AC_SRC_MS] ? AC_IIR_MS : AC_IIR_NONE;
	always_comb begin
		unique case (host_addr)
			AC_A_DATA: rd_mux = divisor_access_bit ? dll_q : receive_buffer_q;
			AC_A_IER: rd_mux = divisor_access_bit ? dlm_q : {4'h0, ier_q};
			AC_A_IIR: rd_mux = iir_val;
			AC_A_LCR: rd_mux = lcr_q;
			AC_A_MCR: rd_mux = {4'h0, ~pins_n_q};
			AC_A_LSR: rd_mux = {1'b0, txb.hold_empty && txb.shift_empty, txb.hold_empty,
				1'b0, fe_q, pe_q, oe_q, dr_q};
			AC_A_MSR: rd_mux = {mod_now, delta_q};
			default: rd_mux = scr_q;
		endcase
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= host_read_strobe ? rd_mux : 8'h00;
		end
	end
	assign host_rd_data = rd_data_q;

	default clocking dcb @(posedge clock); endclocking
	default disable iff (!nrst);
	a_rx_int_tick: assert property (rx_stop_q && tick_q |=>
		pend_q[AC_SRC_RDA] && dr_q && !rx_stop_q)
		else $error("receive interrupt not one tick after stop");
	a_rx_read_clr: assert property ((rd_rbr || rd_lsr) && !rx_done |=> !pend_q[AC_SRC_RDA])
		else $error("receiver read did not clear interrupt");
	a_thr_write_clr: assert property (wr_thr && !txb.tx_holding_empty_evt |=> !pend_q[AC_SRC_TX_HOLDING_EMPTY])
		else $error("holding write did not clear interrupt");
	a_iir_read_clr: assert property (rd_iir && !txb.tx_holding_empty_evt |=> !pend_q[AC_SRC_TX_HOLDING_EMPTY])
		else $error("identification read did not clear interrupt");
	a_modem_set: assert property ($changed(sync2_q[2:1]) && ms_live_q ##1 ier_q[AC_SRC_MS]
		|-> interrupt_out)
		else $error("modem change did not raise interrupt");
	a_msr_read_clr: assert property (rd_msr && mod_chg == 4'h0 |=>
		!pend_q[AC_SRC_MS] && delta_q == 4'h0)
		else $error("modem status read did not clear");
	a_mcr_pins: assert property (wr_mcr |=> rts_n == !$past(host_wr_data[AC_MCR_RTS]) &&
		dtr_n == !$past(host_wr_data[AC_MCR_DTR]))
		else $error("modem control pins not updated");
	a_reset_state: assert property ($rose(nrst) |-> serial_out && !dr_q &&
		txb.hold_empty && txb.shift_empty && rts_n && dtr_n)
		else $error("reset state wrong");
	a_divisor_access_bit_map: assert property (host_write_strobe && divisor_access_bit && host_addr == AC_A_DATA |->
		!txb.wr ##1 dll_q == $past(host_wr_data))
		else $error("divisor access not honoured");
	a_irq_masked: assert property (interrupt_out |-> |(pend_q & ier_q))
		else $error("masked source reached interrupt");
	c_rx_irq: cover property (rx_done ##1 interrupt_out);
	c_tx_holding_empty_irq: cover property (txb.tx_holding_empty_evt ##1 pend_q[AC_SRC_TX_HOLDING_EMPTY]);
	c_ms_irq: cover property (|mod_chg ##1 pend_q[AC_SRC_MS]);
endmodule
`default_nettype wire

/* tb/ac_line_model.sv */
// far-end serial line model: sends characters in, decodes characters out
`timescale 1ns/10ps
`default_nettype none
module ac_line_model #(
	parameter int BIT_CLKS = 16
) (
	// clock
	input wire logic clock,
	// serial line
	input wire logic serial_out,
	output logic serial_in
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;

	// idle line is mark, as any real far end leaves it
	initial serial_in = 1'b1;

	// one frame: start, eight data bits lsb first, one stop
	task automatic send(input logic [7:0] d);
		logic [9:0] fr;
		fr = {1'b1, d, 1'b0};
		@(posedge clock); // launch bits on an edge, like every other bench input
		for (int i = 0; i < 10; i++) begin
			serial_in <= fr[i];
			repeat (BIT_CLKS) @(posedge clock);
		end
	endtask

	// decode mid-bit; a bad stop is pushed inverted so the compare fails
	always begin
		@(negedge serial_out);
		repeat (BIT_CLKS / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clock);
			sh[i] = serial_out;
		end
		repeat (BIT_CLKS) @(posedge clock);
		rx_q.push_back((serial_out === 1'b1) ? sh : ~sh);
	end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the serial channel core
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ac_pkg::*;
	logic clock, nrst;
	logic [2:0] host_addr;
	logic [7:0] host_wr_data, host_rd_data, rd_v, b;
	logic host_write_strobe, host_read_strobe;
	logic serial_in, serial_out, cts_n, dsr_n, carrier_detect_in_n;
	logic rts_n, dtr_n, out1_n, out2_n, interrupt_out;
	logic [3:0] dm;
	logic [7:0] q_tx[$];
	int err_total, compares, n, f, d0;

	ac_uart dut_u (
		.clock(clock), .nrst(nrst),
		.host_addr(host_addr), .host_wr_data(host_wr_data),
		.host_write_strobe(host_write_strobe), .host_read_strobe(host_read_strobe),
		.host_rd_data(host_rd_data),
		.serial_in(serial_in), .serial_out(serial_out),
		.cts_n(cts_n), .dsr_n(dsr_n), .ri_n(1'b1), .carrier_detect_in_n(carrier_detect_in_n),
		.rts_n(rts_n), .dtr_n(dtr_n), .out1_n(out1_n), .out2_n(out2_n),
		.interrupt_out(interrupt_out)
	);

	ac_line_model line_u (
		.clock(clock),
		.serial_out(serial_out),
		.serial_in(serial_in)
	);

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// host bus: one-cycle strobes, read data taken the cycle after
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		host_addr <= a;
		host_wr_data <= d;
		host_write_strobe <= 1'b1;
		@(posedge clock);
		host_write_strobe <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		host_addr <= a;
		host_read_strobe <= 1'b1;
		@(posedge clock);
		host_read_strobe <= 1'b0;
		#1;
		d = host_rd_data;
	endtask

	// advance one cycle and count it; sample after the edge settles
	task automatic tick(inout int c);
		@(posedge clock);
		#1;
		c++;
	endtask

	task automatic wait_int(input int lim, inout int c);
		while (interrupt_out !== 1'b1 && c < lim) tick(c);
	endtask

	// hang guard, far beyond the fewer than a thousand cycles the run needs
	initial begin
		#100000;
		err_total++;
		end_sim();
	end

	initial begin
		void'($urandom(32'ha78c3d51));
		nrst = 1'b0;
		host_addr = 3'h0;
		host_wr_data = 8'h00;
		host_write_strobe = 1'b0;
		host_read_strobe = 1'b0;
		cts_n = 1'b1;
		dsr_n = 1'b1;
		carrier_detect_in_n = 1'b1;
		err_total = 0;
		compares = 0;
		repeat (3) @(posedge clock);
		chk({4'h0, serial_out, rts_n, dtr_n, interrupt_out}, 8'h0e);
		nrst <= 1'b1;
		rd(AC_A_LSR, rd_v);
		chk(rd_v, 8'h60);

		// offsets 0 and 1 switch to the divisor under the access bit
		wr(AC_A_IER, 8'h05);
		wr(AC_A_LCR, 8'h83);
		wr(AC_A_DATA, 8'h01);
		rd(AC_A_IER, rd_v);
		chk(rd_v, 8'h00);
		rd(AC_A_DATA, rd_v);
		chk(rd_v, 8'h01);
		wr(AC_A_LCR, 8'h03);
		rd(AC_A_IER, rd_v);
		chk(rd_v, 8'h05);

		// modem control outputs follow each write
		for (int i = 0; i < 6; i++) begin
			b = 8'($urandom % 16);
			wr(AC_A_MCR, b);
			chk({4'h0, out2_n, out1_n, rts_n, dtr_n}, {4'h0, ~b[3:0]});
		end

		// modem change held back while its enable is off
		wr(AC_A_IER, 8'h00);
		@(posedge clock);
		cts_n <= 1'b0;
		repeat (6) @(posedge clock);
		#1;
		chk({7'h0, interrupt_out}, 8'h00);
		wr(AC_A_IER, 8'h08);
		chk({7'h0, interrupt_out}, 8'h01);
		rd(AC_A_MSR, rd_v);
		chk(rd_v, 8'h11);
		chk({7'h0, interrupt_out}, 8'h00);
		for (int i = 0; i < 6; i++) begin
			@(posedge clock);
			case (i % 3)
				0: cts_n <= ~cts_n;
				1: dsr_n <= ~dsr_n;
				default: carrier_detect_in_n <= ~carrier_detect_in_n;
			endcase
			dm = (i % 3 == 0) ? 4'h1 : (i % 3 == 1) ? 4'h2 : 4'h8;
			n = 0;
			wait_int(10, n);
			chk(8'(n < 10), 8'h01);
			rd(AC_A_MSR, rd_v);
			chk(rd_v, {~carrier_detect_in_n, 1'b0, ~dsr_n, ~cts_n, dm});
			chk({7'h0, interrupt_out}, 8'h00);
		end

		// transmit: start bit and holding-empty timing from the write edge
		wr(AC_A_IER, 8'h02);
		wr(AC_A_IIR, 8'h0f);
		b = 8'($urandom);
		q_tx.push_back(b);
		wr(AC_A_DATA, b);
		n = 1;
		while (serial_out !== 1'b0 && n < 40) tick(n);
		f = n;
		chk(8'(n >= 8 && n <= 24), 8'h01);
		wait_int(60, n);
		chk(8'(n >= 16 && n <= 32), 8'h01);
		d0 = n - f;
		rd(AC_A_IIR, rd_v);
		chk(rd_v, AC_IIR_TX_HOLDING_EMPTY);
		chk({7'h0, interrupt_out}, 8'h00);
		n = n + 2;
		// stop position is nine bit times after the start bit edge
		while (n < f + 144) tick(n);
		wait_int(f + 170, n);
		chk(8'(n - f - 144), 8'(AC_EVT_TICKS));
		chk(8'(d0 >= 8 && d0 <= 9), 8'h01);
		b = 8'($urandom);
		q_tx.push_back(b);
		wr(AC_A_DATA, b);
		chk({7'h0, interrupt_out}, 8'h00);
		repeat (220) @(posedge clock);
		chk(8'(line_u.rx_q.size()), 8'(q_tx.size()));
		for (int i = 0; i < q_tx.size() && i < line_u.rx_q.size(); i++) begin
			chk(line_u.rx_q[i], q_tx[i]);
		end

		// receive: data interrupt, cleared by buffer read then by status read
		wr(AC_A_IER, 8'h01);
		for (int i = 0; i < 2; i++) begin
			b = 8'($urandom);
			n = 0;
			fork
				line_u.send(b);
				wait_int(170, n);
			join
			chk(8'(n >= 150 && n <= 160), 8'h01);
			if (i == 1) begin
				rd(AC_A_LSR, rd_v);
				chk(rd_v, 8'h61);
				chk({7'h0, interrupt_out}, 8'h00);
			end
			rd(AC_A_DATA, rd_v);
			chk(rd_v, b);
			chk({7'h0, interrupt_out}, 8'h00);
		end
		end_sim();
	end
endmodule
`default_nettype wire
